// ==== rtl/qiw_map.vh ====
// Constants for the indirect write and command generator block.
`ifndef QIW_MAP_VH
`define QIW_MAP_VH
`define QIW_SRAM_W     32
`define QIW_SRAM_D     8
`define QIW_SRAM_AW    3
`define QIW_LEG_W      8
`define QIW_LEG_D      4
`define QIW_LEG_AW     2
`define QIW_PAGE_BYTES 16'h0010
`define QIW_WM_OFF     16'hFFFF
`define QIW_PRG_NADR   3'h3
`define QIW_OPS_MAX    2'h2
`define QIW_DUMMY_BYTE 8'h00
`endif

// ==== rtl/qiw_sync.v ====
// Two-flop synchroniser for signals entering the block clock domain.
`timescale 1ns/1ps
module qiw_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule

// ==== rtl/qiw_fifo.v ====
// Flop-based FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/1ps
module qiw_fifo #(
  parameter W  = 32,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_clr,
  input  wire          i_in_valid,
  output wire          o_in_ready,
  input  wire [W-1:0]  i_in_data,
  output wire          o_out_valid,
  input  wire          i_out_ready,
  output wire [W-1:0]  o_out_data,
  output wire [AW:0]   o_count
);
  localparam [AW:0] FULL = D[AW:0];
  reg  [W-1:0] mem_ff [0:D-1];
  reg  [AW-1:0] wp_ff;
  reg  [AW-1:0] rp_ff;
  reg  [AW:0]   cnt_ff;
  wire          push;
  wire          pop;

  assign o_in_ready  = (cnt_ff != FULL);
  assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem_ff[rp_ff];
  assign o_count     = cnt_ff;

  always @(posedge i_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_ff  <= {AW{1'b0}};
      rp_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (i_clr) begin
      wp_ff  <= {AW{1'b0}};
      rp_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop) rp_ff <= rp_ff + 1'b1;
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ==== rtl/qiw_ctrl.v ====
// Indirect write staging, operation queue, legacy FIFOs and command generator.
// Summary of operation
// - Start address and byte count are loaded, then the write-start bit begins transfer.
// - Surplus bytes of a final write beyond the remaining count are dropped.
// - Writes enter the SRAM at once while room exists, otherwise the port waits.
// - Programming starts on a full page in SRAM or on all remaining bytes.
// - A watermark event fires when the SRAM fill falls below the write watermark.
// - A watermark of all ones switches the watermark event off.
// - Out-of-range data-port accesses go to the direct path when it is enabled.
// - Out-of-range accesses with the direct path disabled get an error response.
// - The write-cancel bit aborts the indirect write in progress.
// - A second indirect operation may be triggered while one runs.
// - A third queued indirect operation raises the reject event.
// - Legacy mode sends port writes to the TX FIFO and reads from the RX FIFO.
// - Legacy mode shifts both ways while chip select is low, byte for byte.
// - Legacy FIFOs hold four bytes; the port waits on a full TX FIFO or an empty RX FIFO.
// - Legacy FIFO levels against thresholds drive TX and RX threshold outputs.
// - Generated commands use opcode, address, dummy, write and read byte counts.
// - The execute pulse starts a command; busy stays high until it ends.
// - A generated command moves at most eight write and eight read data bytes via two data words.
// - Generated commands pre-empt reads but wait for any write sequence.
// - The read partition size in words shrinks the write region of the SRAM.
`timescale 1ns/1ps
`include "qiw_map.vh"
module qiw_ctrl (
  input  wire        I_CLK,
  input  wire        I_RST_N,
  input  wire        I_DP_VALID,
  input  wire        I_DP_WRITE,
  input  wire [31:0] I_DP_ADDR,
  input  wire [1:0]  I_DP_SIZE,
  input  wire [31:0] I_DP_WDATA,
  output wire        O_DP_READY,
  output reg         O_DP_RESP,
  output reg         O_DP_ERR,
  output reg  [31:0] O_DP_RDATA,
  output reg         O_DIR_VALID,
  output reg         O_DIR_WRITE,
  output reg  [31:0] O_DIR_ADDR,
  output reg  [31:0] O_DIR_WDATA,
  input  wire        I_DIRECT_EN,
  input  wire        I_LEGACY_EN,
  input  wire [31:0] I_TRIG_BASE,
  input  wire [4:0]  I_TRIG_RANGE,
  input  wire [2:0]  I_RD_PART,
  input  wire [23:0] I_WR_START_ADDR,
  input  wire [15:0] I_WR_COUNT,
  input  wire        I_WR_START,
  input  wire        I_WR_CANCEL,
  input  wire [15:0] I_WR_WATERMARK,
  input  wire [7:0]  I_PROG_OPCODE,
  input  wire        I_RD_START,
  input  wire        I_RD_DONE,
  input  wire [2:0]  I_TX_THR,
  input  wire [2:0]  I_RX_THR,
  input  wire [7:0]  I_CMD_OPCODE,
  input  wire [2:0]  I_CMD_NADDR,
  input  wire [3:0]  I_CMD_NDUMMY,
  input  wire [3:0]  I_CMD_NWR,
  input  wire [3:0]  I_CMD_NRD,
  input  wire [31:0] I_CMD_ADDR,
  input  wire [63:0] I_CMD_WDATA,
  input  wire        I_CMD_EXEC,
  output reg         O_CMD_BUSY,
  output reg  [63:0] O_CMD_RDATA,
  output reg         O_RD_YIELD,
  output reg         O_WR_BUSY,
  output reg  [5:0]  O_SRAM_FILL,
  output reg         O_WM_IRQ,
  output reg         O_IND_REJECT,
  output reg         O_TX_THR_IRQ,
  output reg         O_RX_THR_IRQ,
  input  wire        I_SCLK,
  input  wire        I_MISO,
  output reg         O_CS_N,
  output wire        O_MOSI
);
  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_OP   = 3'h1;
  localparam [2:0] PH_ADR  = 3'h2;
  localparam [2:0] PH_DUM  = 3'h3;
  localparam [2:0] PH_WR   = 3'h4;
  localparam [2:0] PH_RD   = 3'h5;
  localparam [2:0] PH_LEG  = 3'h6;
  localparam [2:0] PH_GO   = 3'h7;

  reg         rs1_ff, rs2_ff;
  wire        rst_n = rs2_ff;
  wire [1:0]  pin_s;
  reg         sclk_prev_ff;
  reg  [2:0]  ph_ff, bit_ff;
  reg  [4:0]  cnt_ff;
  reg         pend_ff, own_prog_ff;
  reg  [7:0]  sh_ff, rxs_ff, opc_ff;
  reg  [31:0] addr_ff;
  reg  [2:0]  l_adr_ff;
  reg  [3:0]  l_dum_ff, l_rd_ff;
  reg  [4:0]  l_wr_ff;
  reg  [1:0]  wbi_ff, ops_ff;
  reg         wr_act_ff, q_val_ff, wm_below_ff;
  reg  [23:0] wr_addr_ff, q_addr_ff;
  reg  [15:0] q_cnt_ff, acc_rem_ff, prog_rem_ff, wr_left_ff;
  reg  [5:0]  fill_ff;

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end

  qiw_sync #(.W(2)) u_pin_sync (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .i_d     ({I_SCLK, I_MISO}),
    .o_q     (pin_s)
  );

  wire sclk_rise = pin_s[1] & ~sclk_prev_ff;
  wire sclk_fall = ~pin_s[1] & sclk_prev_ff;
  wire busy_ph   = (ph_ff != PH_IDLE) && (ph_ff != PH_GO);
  wire byte_done = busy_ph & sclk_rise & (bit_ff == 3'h7);
  wire [7:0] rx_byte = {rxs_ff[6:0], pin_s[0]};

  // Data-port decode.
  wire [31:0] trig_mask = ~((32'h1 << I_TRIG_RANGE) - 32'h1);
  wire in_rng = ((I_DP_ADDR ^ I_TRIG_BASE) & trig_mask) == 32'h0;
  wire [15:0] sz_b = (I_DP_SIZE == 2'h0) ? 16'h1 : (I_DP_SIZE == 2'h1) ? 16'h2 : 16'h4;
  wire [15:0] keep = (acc_rem_ff < sz_b) ? acc_rem_ff : sz_b;
  wire [3:0]  w_cnt;
  wire [3:0]  w_cap = 4'h8 - {1'b0, I_RD_PART};
  wire s_in_rdy;
  wire [31:0] s_out;
  wire tx_in_rdy, tx_vld, rx_vld;
  wire [7:0] tx_byte, rx_head;
  wire [2:0] tx_cnt, rx_cnt;

  wire wr_need = wr_act_ff & (acc_rem_ff != 16'h0);
  wire wr_room = s_in_rdy & (w_cnt < w_cap);
  wire ind_wr  = ~I_LEGACY_EN & in_rng & I_DP_WRITE;
  assign O_DP_READY = I_LEGACY_EN ? (I_DP_WRITE ? tx_in_rdy : rx_vld) :
                      (ind_wr & wr_need) ? wr_room : 1'b1;
  wire dp_hit   = I_DP_VALID & O_DP_READY;
  wire s_push   = dp_hit & ind_wr & wr_need;
  wire leg_push = dp_hit & I_LEGACY_EN & I_DP_WRITE;
  wire leg_pop  = dp_hit & I_LEGACY_EN & ~I_DP_WRITE;
  wire out_rng  = dp_hit & ~I_LEGACY_EN & ~in_rng;

  // Next phase after the current one, skipping phases of zero length.
  wire [2:0] a_rd  = (l_rd_ff != 4'h0) ? PH_RD : PH_IDLE;
  wire [2:0] a_wr  = (l_wr_ff != 5'h0) ? PH_WR : a_rd;
  wire [2:0] a_dum = (l_dum_ff != 4'h0) ? PH_DUM : a_wr;
  wire [2:0] a_adr = (l_adr_ff != 3'h0) ? PH_ADR : a_dum;
  reg  [2:0] nx_ph;
  reg  [4:0] cur_len;
  always @* begin
    case (ph_ff)
      PH_GO:   begin nx_ph = PH_OP; cur_len = 5'h1; end
      PH_OP:   begin nx_ph = a_adr; cur_len = 5'h1; end
      PH_ADR:  begin nx_ph = a_dum; cur_len = {2'h0, l_adr_ff}; end
      PH_DUM:  begin nx_ph = a_wr; cur_len = {1'b0, l_dum_ff}; end
      PH_WR:   begin nx_ph = a_rd; cur_len = l_wr_ff; end
      PH_RD:   begin nx_ph = PH_IDLE; cur_len = {1'b0, l_rd_ff}; end
      default: begin nx_ph = PH_IDLE; cur_len = 5'h1; end
    endcase
  end

  wire step     = byte_done | (ph_ff == PH_GO);
  wire last     = (cnt_ff + 5'h1 == cur_len) | (ph_ff == PH_GO);
  wire [2:0] ld_ph  = last ? nx_ph : ph_ff;
  wire [4:0] ld_cnt = last ? 5'h0 : cnt_ff + 5'h1;
  wire leg_step = byte_done & (ph_ff == PH_LEG);
  wire seq_step = step & (ph_ff != PH_LEG);
  wire load_wr  = seq_step & (ld_ph == PH_WR) & own_prog_ff;
  wire s_pop    = load_wr & ((wbi_ff == 2'h3) | (wr_left_ff == 16'h1));
  wire tx_pop   = (leg_step | ((ph_ff == PH_IDLE) & I_LEGACY_EN)) & tx_vld;
  wire [2:0] adr_i  = l_adr_ff - 3'h1 - ld_cnt[2:0];
  wire [31:0] adr_sh = addr_ff >> {adr_i, 3'h0};
  wire [31:0] wd_sh  = s_out >> {wbi_ff, 3'h0};
  wire [63:0] cd_sh  = I_CMD_WDATA >> {ld_cnt[2:0], 3'h0};
  reg  [7:0] ld_byte;
  always @* begin
    case (ld_ph)
      PH_OP:   ld_byte = opc_ff;
      PH_ADR:  ld_byte = adr_sh[7:0];
      PH_WR:   ld_byte = own_prog_ff ? wd_sh[7:0] : cd_sh[7:0];
      default: ld_byte = `QIW_DUMMY_BYTE;
    endcase
  end

  // Program start: a full page or the whole remainder is staged.
  wire [15:0] fill16 = {10'h0, fill_ff};
  wire prog_rdy = wr_act_ff & (prog_rem_ff != 16'h0) &
                  ((fill16 >= `QIW_PAGE_BYTES) | (fill16 >= prog_rem_ff));
  wire [15:0] prog_len = (prog_rem_ff < `QIW_PAGE_BYTES) ? prog_rem_ff : `QIW_PAGE_BYTES;
  wire idle     = (ph_ff == PH_IDLE);
  wire go_prog  = idle & ~I_LEGACY_EN & prog_rdy;
  wire go_cmd   = idle & ~I_LEGACY_EN & ~prog_rdy & O_CMD_BUSY;
  wire tx_end   = seq_step & last & (nx_ph == PH_IDLE);
  wire cancel   = I_WR_CANCEL & wr_act_ff;
  wire wr_fin   = (tx_end & own_prog_ff & (prog_rem_ff == 16'h0)) | cancel;
  wire start    = I_WR_START | I_RD_START;
  wire reject   = start & (ops_ff == `QIW_OPS_MAX);
  wire st_ok    = start & ~reject;
  wire wr_new   = st_ok & I_WR_START;
  wire dec_n    = wr_fin | I_RD_DONE;
  wire wm_on    = (I_WR_WATERMARK != `QIW_WM_OFF);
  wire wm_now   = wr_act_ff & wm_on & ({10'h0, fill_ff} < I_WR_WATERMARK);

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_ff <= 1'b0;
      ph_ff        <= PH_IDLE;
      bit_ff       <= 3'h0;
      cnt_ff       <= 5'h0;
      pend_ff      <= 1'b0;
      sh_ff        <= 8'h00;
      rxs_ff       <= 8'h00;
      own_prog_ff  <= 1'b0;
      opc_ff       <= 8'h00;
      addr_ff      <= 32'h0;
      l_adr_ff     <= 3'h0;
      l_dum_ff     <= 4'h0;
      l_wr_ff      <= 5'h0;
      l_rd_ff      <= 4'h0;
      wbi_ff       <= 2'h0;
      O_CS_N       <= 1'b1;
      O_CMD_BUSY   <= 1'b0;
      O_CMD_RDATA  <= 64'h0;
    end else begin
      sclk_prev_ff <= pin_s[1];
      if (sclk_rise & busy_ph) begin
        rxs_ff  <= rx_byte;
        bit_ff  <= bit_ff + 3'h1;
        pend_ff <= ~byte_done;
      end else if (sclk_fall & pend_ff) begin
        sh_ff   <= {sh_ff[6:0], 1'b0};
        pend_ff <= 1'b0;
      end
      if (I_CMD_EXEC & ~O_CMD_BUSY) O_CMD_BUSY <= 1'b1;
      if (ph_ff == PH_RD && byte_done) begin
        O_CMD_RDATA[{cnt_ff[2:0], 3'h0} +: 8] <= rx_byte;
      end
      if (cancel & own_prog_ff & ~idle) begin
        ph_ff  <= PH_IDLE;
        O_CS_N <= 1'b1;
      end else if (go_prog) begin
        own_prog_ff <= 1'b1;
        opc_ff      <= I_PROG_OPCODE;
        addr_ff     <= {8'h00, wr_addr_ff};
        l_adr_ff    <= `QIW_PRG_NADR;
        l_dum_ff    <= 4'h0;
        l_wr_ff     <= prog_len[4:0];
        l_rd_ff     <= 4'h0;
        ph_ff       <= PH_GO;
      end else if (go_cmd) begin
        own_prog_ff <= 1'b0;
        opc_ff      <= I_CMD_OPCODE;
        addr_ff     <= I_CMD_ADDR;
        l_adr_ff    <= I_CMD_NADDR;
        l_dum_ff    <= I_CMD_NDUMMY;
        l_wr_ff     <= (I_CMD_NWR > 4'h8) ? 5'h8 : {1'b0, I_CMD_NWR};
        l_rd_ff     <= (I_CMD_NRD > 4'h8) ? 4'h8 : I_CMD_NRD;
        O_CMD_RDATA <= 64'h0;
        ph_ff       <= PH_GO;
      end else if (tx_pop) begin
        ph_ff   <= PH_LEG;
        sh_ff   <= tx_byte;
        bit_ff  <= 3'h0;
        pend_ff <= 1'b0;
        O_CS_N  <= 1'b0;
      end else if (leg_step) begin
        ph_ff  <= PH_IDLE;
        O_CS_N <= 1'b1;
      end else if (seq_step) begin
        ph_ff   <= ld_ph;
        cnt_ff  <= ld_cnt;
        sh_ff   <= ld_byte;
        bit_ff  <= 3'h0;
        pend_ff <= 1'b0;
        O_CS_N  <= (ld_ph == PH_IDLE);
        if (load_wr) wbi_ff <= wbi_ff + 2'h1;
        if (tx_end & ~own_prog_ff) O_CMD_BUSY <= 1'b0;
      end
      if (wr_fin) wbi_ff <= 2'h0;
    end
  end

  assign O_MOSI = sh_ff[7];

  // Indirect write bookkeeping and the two-deep operation queue.
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_ff   <= 1'b0;
      q_val_ff    <= 1'b0;
      wr_addr_ff  <= 24'h0;
      q_addr_ff   <= 24'h0;
      q_cnt_ff    <= 16'h0;
      acc_rem_ff  <= 16'h0;
      prog_rem_ff <= 16'h0;
      wr_left_ff  <= 16'h0;
      fill_ff     <= 6'h0;
      ops_ff      <= 2'h0;
      wm_below_ff <= 1'b0;
    end else begin
      ops_ff <= ops_ff + {1'b0, st_ok} - {1'b0, dec_n & (ops_ff != 2'h0)};
      wm_below_ff <= wm_now;
      fill_ff <= fill_ff + (s_push ? keep[5:0] : 6'h0) - {5'h0, load_wr};
      if (s_push) acc_rem_ff <= acc_rem_ff - keep;
      if (load_wr) wr_left_ff <= wr_left_ff - 16'h1;
      if (go_prog) begin
        wr_addr_ff  <= wr_addr_ff + {8'h00, prog_len};
        prog_rem_ff <= prog_rem_ff - prog_len;
      end
      if (wr_fin) begin
        wr_act_ff <= q_val_ff;
        q_val_ff  <= 1'b0;
        if (cancel) fill_ff <= 6'h0;
        if (q_val_ff) begin
          wr_addr_ff  <= q_addr_ff;
          acc_rem_ff  <= q_cnt_ff;
          prog_rem_ff <= q_cnt_ff;
          wr_left_ff  <= q_cnt_ff;
        end else begin
          acc_rem_ff  <= 16'h0;
          prog_rem_ff <= 16'h0;
        end
      end
      if (wr_new & ~wr_act_ff & ~q_val_ff) begin
        wr_act_ff   <= 1'b1;
        wr_addr_ff  <= I_WR_START_ADDR;
        acc_rem_ff  <= I_WR_COUNT;
        prog_rem_ff <= I_WR_COUNT;
        wr_left_ff  <= I_WR_COUNT;
      end else if (wr_new & ~q_val_ff) begin
        q_val_ff  <= 1'b1;
        q_addr_ff <= I_WR_START_ADDR;
        q_cnt_ff  <= I_WR_COUNT;
      end
    end
  end

  // Port responses, direct forwarding and event outputs.
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_DP_RESP    <= 1'b0;
      O_DP_ERR     <= 1'b0;
      O_DP_RDATA   <= 32'h0;
      O_DIR_VALID  <= 1'b0;
      O_DIR_WRITE  <= 1'b0;
      O_DIR_ADDR   <= 32'h0;
      O_DIR_WDATA  <= 32'h0;
      O_WM_IRQ     <= 1'b0;
      O_IND_REJECT <= 1'b0;
      O_TX_THR_IRQ <= 1'b0;
      O_RX_THR_IRQ <= 1'b0;
      O_RD_YIELD   <= 1'b0;
      O_WR_BUSY    <= 1'b0;
      O_SRAM_FILL  <= 6'h0;
    end else begin
      O_DP_RESP   <= dp_hit;
      O_DP_ERR    <= out_rng & ~I_DIRECT_EN;
      O_DP_RDATA  <= leg_pop ? {24'h0, rx_head} : 32'h0;
      O_DIR_VALID <= out_rng & I_DIRECT_EN;
      if (out_rng & I_DIRECT_EN) begin
        O_DIR_WRITE <= I_DP_WRITE;
        O_DIR_ADDR  <= I_DP_ADDR;
        O_DIR_WDATA <= I_DP_WDATA;
      end
      O_WM_IRQ     <= wm_now & ~wm_below_ff;
      O_IND_REJECT <= reject;
      O_TX_THR_IRQ <= (tx_cnt <= I_TX_THR);
      O_RX_THR_IRQ <= (I_RX_THR != 3'h0) & (rx_cnt >= I_RX_THR);
      O_RD_YIELD   <= O_CMD_BUSY;
      O_WR_BUSY    <= wr_act_ff;
      O_SRAM_FILL  <= fill_ff;
    end
  end

  // Write partition of the SRAM; surplus bytes of the last word are never shifted out.
  qiw_fifo #(.W(`QIW_SRAM_W), .D(`QIW_SRAM_D), .AW(`QIW_SRAM_AW)) u_sram (
    .i_clk       (I_CLK),
    .i_rst_n     (rst_n),
    .i_clr       (cancel),
    .i_in_valid  (s_push),
    .o_in_ready  (s_in_rdy),
    .i_in_data   (I_DP_WDATA),
    .o_out_valid (),
    .i_out_ready (s_pop),
    .o_out_data  (s_out),
    .o_count     (w_cnt)
  );

  // Legacy FIFOs are four bytes deep; an RX byte that finds it full is lost.
  qiw_fifo #(.W(`QIW_LEG_W), .D(`QIW_LEG_D), .AW(`QIW_LEG_AW)) u_tx (
    .i_clk       (I_CLK),
    .i_rst_n     (rst_n),
    .i_clr       (1'b0),
    .i_in_valid  (leg_push),
    .o_in_ready  (tx_in_rdy),
    .i_in_data   (I_DP_WDATA[7:0]),
    .o_out_valid (tx_vld),
    .i_out_ready (tx_pop),
    .o_out_data  (tx_byte),
    .o_count     (tx_cnt)
  );

  qiw_fifo #(.W(`QIW_LEG_W), .D(`QIW_LEG_D), .AW(`QIW_LEG_AW)) u_rx (
    .i_clk       (I_CLK),
    .i_rst_n     (rst_n),
    .i_clr       (1'b0),
    .i_in_valid  (leg_step),
    .o_in_ready  (),
    .i_in_data   (rx_byte),
    .o_out_valid (rx_vld),
    .i_out_ready (leg_pop),
    .o_out_data  (rx_head),
    .o_count     (rx_cnt)
  );
endmodule

// ==== verification/qiw_flash_model.sv ====
// Serial flash partner: clocks each frame, records MOSI bytes and returns a counting pattern.
`timescale 1ns/1ps
module qiw_flash_model (
  input  wire  i_cs_n,
  input  wire  i_mosi,
  output logic o_sclk,
  output logic o_miso
);
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  logic [7:0] bytes_q [$];
  int         nbit;

  // The clock stands still between frames; the released data line shows the inverse level.
  initial begin
    o_sclk = 1'b0;
    o_miso = 1'b1;
    forever begin
      @(negedge i_cs_n);
      nbit  = 0;
      tx_sr = 8'hA0;
      while (!i_cs_n) begin
        o_miso = tx_sr[7 - nbit % 8];
        #80 o_sclk = 1'b1;
        rx_sr = {rx_sr[6:0], i_mosi};
        nbit++;
        if (nbit % 8 == 0) begin
          bytes_q.push_back(rx_sr);
          tx_sr++;
        end
        #80 o_sclk = 1'b0;
      end
      o_miso = ~o_miso;
    end
  end
endmodule

// ==== verification/qiw_ctrl_chk.sv ====
// Port-level assertions for the indirect write and command generator block.
`timescale 1ns/1ps
module qiw_ctrl_chk (
  input logic        I_CLK,
  input logic        I_RST_N,
  input logic        I_DP_VALID,
  input logic [31:0] I_DP_ADDR,
  input logic        O_DP_READY,
  input logic        O_DP_RESP,
  input logic        O_DP_ERR,
  input logic        O_DIR_VALID,
  input logic        I_DIRECT_EN,
  input logic        I_LEGACY_EN,
  input logic [31:0] I_TRIG_BASE,
  input logic [4:0]  I_TRIG_RANGE,
  input logic        I_WR_START,
  input logic        I_RD_START,
  input logic        O_IND_REJECT,
  input logic [15:0] I_WR_WATERMARK,
  input logic        O_WM_IRQ,
  input logic [5:0]  O_SRAM_FILL,
  input logic        I_CMD_EXEC,
  input logic        O_CMD_BUSY,
  input logic        O_WR_BUSY
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  wire        take_w = I_DP_VALID && O_DP_READY;
  // Legacy mode claims every address, so only non-legacy accesses count as off-window.
  wire        off_w  = (((I_DP_ADDR ^ I_TRIG_BASE) >> I_TRIG_RANGE) != 32'h0) && !I_LEGACY_EN;
  wire [15:0] fill_w = {10'h000, O_SRAM_FILL};

  AST_RESP_NEXT: assert property (take_w |=> O_DP_RESP)
    else $error("data port response missing after accept");
  AST_NO_STRAY_RESP: assert property (!take_w |=> !O_DP_RESP)
    else $error("data port response without an accepted request");
  AST_ERR_OFF_RANGE: assert property (take_w && off_w && !I_DIRECT_EN |=> O_DP_ERR && !O_DIR_VALID)
    else $error("off-window access without direct path not refused");
  AST_DIRECT_FWD: assert property (take_w && off_w && I_DIRECT_EN |=> O_DIR_VALID && !O_DP_ERR)
    else $error("off-window access not forwarded to direct path");
  AST_LEGACY_NO_ERR: assert property (take_w && I_LEGACY_EN |=> !O_DP_ERR && !O_DIR_VALID)
    else $error("legacy access left the legacy path");
  AST_REJECT_CAUSE: assert property (O_IND_REJECT |-> $past(I_WR_START || I_RD_START))
    else $error("reject pulse without a start request");
  AST_WM_OFF: assert property (I_WR_WATERMARK == 16'hFFFF && $stable(I_WR_WATERMARK) |-> !O_WM_IRQ)
    else $error("watermark event while switched off");
  AST_WM_BELOW: assert property (O_WM_IRQ |-> fill_w < I_WR_WATERMARK || $past(fill_w) < I_WR_WATERMARK)
    else $error("watermark event with fill not below watermark");
  AST_EXEC_BUSY: assert property (I_CMD_EXEC |=> O_CMD_BUSY)
    else $error("command busy not raised by execute");
  AST_BUSY_SOURCE: assert property (!O_CMD_BUSY && !I_CMD_EXEC |=> !O_CMD_BUSY)
    else $error("command busy raised without execute");
  AST_WR_BUSY_START: assert property (I_WR_START && !O_WR_BUSY |-> ##2 (O_WR_BUSY || $past(O_IND_REJECT)))
    else $error("indirect write not active two cycles after start");

  cover property (O_IND_REJECT);
  cover property (take_w && off_w && !I_DIRECT_EN);
  cover property ($fell(O_CMD_BUSY));
endmodule

// ==== verification/qiw_ctrl_tb.sv ====
// Self-checking bench: routing table, indirect write, queue, cancel, command and legacy.
`timescale 1ns/1ps
module qiw_ctrl_tb;
  logic        I_CLK, I_RST_N, I_DP_VALID, I_DP_WRITE, I_DIRECT_EN, I_LEGACY_EN;
  logic        I_WR_START, I_WR_CANCEL, I_RD_START, I_RD_DONE, I_CMD_EXEC;
  logic [1:0]  I_DP_SIZE;
  logic [2:0]  I_RD_PART, I_TX_THR, I_RX_THR, I_CMD_NADDR;
  logic [3:0]  I_CMD_NDUMMY, I_CMD_NWR, I_CMD_NRD;
  logic [4:0]  I_TRIG_RANGE;
  logic [5:0]  O_SRAM_FILL;
  logic [7:0]  I_PROG_OPCODE, I_CMD_OPCODE;
  logic [15:0] I_WR_COUNT, I_WR_WATERMARK;
  logic [23:0] I_WR_START_ADDR;
  logic [31:0] I_DP_ADDR, I_DP_WDATA, I_TRIG_BASE, I_CMD_ADDR, O_DP_RDATA, O_DIR_ADDR;
  logic [31:0] O_DIR_WDATA, rdat;
  logic [63:0] I_CMD_WDATA, O_CMD_RDATA;
  wire         I_SCLK, I_MISO;
  logic        O_DP_READY, O_DP_RESP, O_DP_ERR, O_DIR_VALID, O_DIR_WRITE, O_CMD_BUSY;
  logic        O_RD_YIELD, O_WR_BUSY, O_WM_IRQ, O_IND_REJECT, O_TX_THR_IRQ, O_RX_THR_IRQ;
  logic        O_CS_N, O_MOSI, took;
  logic [2:0]  rsp;
  logic [7:0]  fb [$];
  int          bad_count, compares, rej_n, wm_n, stall, n, k;
  // Row: address, direct enable, write, expected error, expected forward.
  logic [35:0] rows [4] = '{{32'h0000_1010, 4'h0}, {32'h0000_9000, 4'h6},
                            {32'h0000_9000, 4'hD}, {32'h0000_9004, 4'h2}};

  qiw_ctrl u_qiw_ctrl (.*);
  qiw_flash_model u_qiw_flash_model (.i_cs_n(O_CS_N), .i_mosi(O_MOSI), .o_sclk(I_SCLK),
    .o_miso(I_MISO));

  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  // Pulses are counted at the edge so a one-cycle event cannot be missed by sampling.
  always @(posedge I_CLK) begin
    took  <= I_DP_VALID && O_DP_READY;
    rej_n <= rej_n + O_IND_REJECT;
    wm_n  <= wm_n + O_WM_IRQ;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic guard(input logic ok);
    if (!ok) begin
      bad_count++;
      $display("mismatch wait expected done seen timeout");
      print_verdict();
    end
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    @(negedge I_CLK);
    s = 1'b0;
    @(negedge I_CLK);
  endtask
  // Holds the request until accepted, then leaves one idle edge before the next request.
  task automatic dp(input logic wr, input logic [31:0] adr, input logic [31:0] dat);
    I_DP_VALID = 1'b1;
    I_DP_WRITE = wr;
    I_DP_ADDR  = adr;
    I_DP_WDATA = dat;
    stall = 0;
    do begin
      @(posedge I_CLK);
      #1;
      stall++;
    end while (!took && stall < 5000);
    guard(took);
    rsp  = {O_DP_RESP, O_DP_ERR, O_DIR_VALID};
    rdat = O_DP_RDATA;
    @(negedge I_CLK);
    I_DP_VALID = 1'b0;
    @(negedge I_CLK);
  endtask

  initial begin
    I_RST_N = 1'b0;
    {I_DP_VALID, I_DP_WRITE, I_DIRECT_EN, I_LEGACY_EN, I_WR_START, I_WR_CANCEL} = 6'h00;
    {I_RD_START, I_RD_DONE, I_CMD_EXEC} = 3'h0;
    I_DP_SIZE = 2'h2;
    I_DP_ADDR = 32'h0;
    I_DP_WDATA = 32'h0;
    I_TRIG_BASE = 32'h0000_1000;
    I_TRIG_RANGE = 5'h08;
    I_RD_PART = 3'h4;
    I_WR_START_ADDR = 24'h012345;
    I_WR_COUNT = 16'h0012;
    I_WR_WATERMARK = 16'h0014;
    I_PROG_OPCODE = 8'h3C;
    I_TX_THR = 3'h1;
    I_RX_THR = 3'h4;
    I_CMD_OPCODE = 8'h5A;
    I_CMD_NADDR = 3'h3;
    I_CMD_NDUMMY = 4'h1;
    I_CMD_NWR = 4'h2;
    I_CMD_NRD = 4'h8;
    I_CMD_ADDR = 32'h00AB_CDEF;
    I_CMD_WDATA = 64'h0000_0000_0000_7766;
    repeat (2) @(negedge I_CLK);
    chk("rst_out", {O_CS_N, O_CMD_BUSY, O_WR_BUSY}, 3'h4);
    I_RST_N = 1'b1;
    repeat (3) @(negedge I_CLK);
    $display("reset test done");
    foreach (rows[r]) begin
      I_DIRECT_EN = rows[r][3];
      dp(rows[r][2], rows[r][35:4], 32'h0000_00C3);
      chk("route", rsp, {1'b1, rows[r][1:0]});
    end
    chk("dir", {O_DIR_WRITE, O_DIR_ADDR[30:0], O_DIR_WDATA}, 64'h8000_9000_0000_00C3);
    I_DIRECT_EN = 1'b0;
    $display("routing test done");
    pls(I_WR_START);
    pls(I_RD_START);
    pls(I_RD_START);
    pls(I_RD_DONE);
    chk("reject", rej_n, 1);
    // Last word carries two surplus bytes; the write region holds exactly one page.
    for (k = 0; k < 5; k++) begin
      dp(1'b1, 32'h0000_1000, 32'h1312_1110 + 32'h0404_0404 * k);
      if (k == 3)
        chk("fill", O_SRAM_FILL, 6'h10);
    end
    chk("stall", stall > 20, 1'b1);
    for (n = 0; n < 9000 && O_WR_BUSY; n++)
      @(negedge I_CLK);
    guard(!O_WR_BUSY);
    fb = u_qiw_flash_model.bytes_q;
    chk("prog_len", fb.size(), 26);
    chk("page1", {fb[0], fb[1], fb[2], fb[3], fb[4]}, 40'h3C01234510);
    chk("page2", {fb[20], fb[21], fb[22], fb[23], fb[24], fb[25]}, 48'h3C0123552021);
    chk("wm", wm_n > 0, 1'b1);
    $display("indirect write test done");
    I_WR_WATERMARK = 16'hFFFF;
    I_WR_COUNT = 16'h0008;
    u_qiw_flash_model.bytes_q.delete();
    @(negedge I_CLK);
    k = wm_n;
    pls(I_WR_START);
    dp(1'b1, 32'h0000_1004, 32'hDEAD_BEEF);
    pls(I_WR_CANCEL);
    repeat (3) @(negedge I_CLK);
    chk("cancel", {O_WR_BUSY, O_SRAM_FILL, u_qiw_flash_model.bytes_q.size()}, 0);
    chk("wm_off", wm_n, k);
    $display("cancel test done");
    pls(I_CMD_EXEC);
    chk("yield", O_RD_YIELD, 1'b1);
    for (n = 0; n < 3000 && O_CMD_BUSY; n++)
      @(negedge I_CLK);
    guard(!O_CMD_BUSY);
    fb = u_qiw_flash_model.bytes_q;
    chk("cmd_len", fb.size(), 15);
    chk("cmd", {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5], fb[6], fb[14]}, 64'h5AABCDEF00667700);
    chk("cmd_rd", O_CMD_RDATA, 64'hAEAD_ACAB_AAA9_A8A7);
    $display("command test done");
    I_LEGACY_EN = 1'b1;
    u_qiw_flash_model.bytes_q.delete();
    @(negedge I_CLK);
    for (k = 0; k < 4; k++) begin
      dp(1'b1, 32'h0000_9000, 32'h0000_00C0 + k);
      chk("leg_wr", rsp, 3'h4);
    end
    for (n = 0; n < 3000 && O_RX_THR_IRQ !== 1'b1; n++)
      @(negedge I_CLK);
    guard(O_RX_THR_IRQ === 1'b1);
    fb = u_qiw_flash_model.bytes_q;
    chk("leg_tx", {fb[0], fb[1], fb[2], fb[3]}, 32'hC0C1C2C3);
    for (k = 0; k < 4; k++) begin
      dp(1'b0, 32'h0000_2000, 32'h0);
      chk("leg_rd", rdat, 32'h0000_00A0 + k);
    end
    chk("thr", {O_TX_THR_IRQ, O_RX_THR_IRQ}, 2'h2);
    I_DP_VALID = 1'b1;
    I_DP_WRITE = 1'b0;
    #1;
    chk("rx_empty", O_DP_READY, 1'b0);
    @(negedge I_CLK);
    I_DP_VALID = 1'b0;
    $display("legacy test done");
    print_verdict();
  end
endmodule

bind qiw_ctrl qiw_ctrl_chk u_qiw_ctrl_chk (.*);
